/* bench/ssps_host_model.sv */
// host model: drives chip select and reads the status pins
`timescale 1ns/10ps
module ssps_host_model (
    // clock and control from the bench
    input wire logic i_clk,
    input wire logic i_select,
    // status pins
    input wire logic i_pin_a,
    input wire logic i_pin_b,
    input wire logic i_pin_b_oe_n,
    // host side
    output logic o_cs_n,
    output logic o_b_level,
    output logic [15:0] o_a_edges
);
    logic b_last = 1'b0;
    logic a_last = 1'b0;
    logic b_wire;
    // a released line has no pull, so it shows the inverse of its last level
    assign b_wire = i_pin_b_oe_n ? ~b_last : i_pin_b;
    initial o_cs_n = 1'b1;
    initial o_b_level = 1'b0;
    initial o_a_edges = 16'h0000;
    // select changes just after the edge; pin b is only read while deselected
    always @(posedge i_clk) begin
        o_cs_n <= ~i_select;
        // remember only what the pin itself drove
        if (!i_pin_b_oe_n) begin
            b_last <= i_pin_b;
        end
        a_last <= i_pin_a;
        if (o_cs_n) begin
            o_b_level <= b_wire;
        end
        if (i_pin_a && !a_last) begin
            o_a_edges <= o_a_edges + 16'h0001;
        end
    end
endmodule // ssps_host_model

/* bench/status_output_pin_selector_tb_top.sv */
// self-checking bench for the status output pin selector
`timescale 1ns/10ps
module status_output_pin_selector_tb_top;
    import ssps_pkg::*;
    //==========================================================
    // table row: stimulus beside the expected pin c result
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] cfg;
        logic [6:0] fill;
        logic [7:0] rssi;
        logic busy;
        logic sync;
        logic lvl;
        logic oe_n;
    } ssps_row_s;
    localparam int NROW = 13;
    ssps_row_s rows [NROW] = '{
        '{32'h000F_0001, 8'h00, 7'h40, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
        '{32'h000F_0001, 8'h00, 7'h41, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0},
        '{32'h000F_8001, 8'h09, 7'h00, 8'h7F, 1'b0, 1'b0, 1'b1, 1'b0},
        '{32'h000F_8001, 8'h09, 7'h00, 8'h80, 1'b0, 1'b0, 1'b0, 1'b0},
        '{32'h000F_8000, 8'h09, 7'h00, 8'hFF, 1'b1, 1'b0, 1'b1, 1'b0},
        '{32'h000F_8002, 8'h09, 7'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0},
        '{32'h000F_8002, 8'h09, 7'h00, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0},
        '{32'h000F_8003, 8'h09, 7'h00, 8'h7F, 1'b0, 1'b0, 1'b1, 1'b0},
        '{32'h000F_8003, 8'h09, 7'h00, 8'h7F, 1'b1, 1'b0, 1'b0, 1'b0},
        '{32'h000F_0001, 8'h0B, 7'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0},
        '{32'h000F_0001, 8'h0B, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
        '{32'h000F_0001, 8'h07, 7'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0},
        '{32'h000F_0001, 8'h2E, 7'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1}
    };
    logic clk, rst_n, psel, pen, pwr, eop, under, flush, busy, sclk, sync, sel;
    logic [7:0] paddr, rssi;
    logic [31:0] pwdata, prdata;
    logic [6:0] fill;
    logic pready, pslverr, pa, pa_oe_n, temp_en, pb, pb_oe_n, pc, pc_oe_n, irq, cs_n, b_level;
    logic [15:0] a_edges;
    int n_errors, n_compared;
    //==========================================================
    // design and host
    ssps_top DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_RX_FILL(fill), .I_RX_EOP(eop), .I_TX_UNDERFLOW(under), .I_TX_FLUSH(flush),
        .I_RSSI(rssi), .I_RX_BUSY(busy), .I_SER_CLK(sclk), .I_SYNC_MODE(sync), .I_CS_N(cs_n),
        .O_PIN_A(pa), .O_PIN_A_OE_N(pa_oe_n), .O_TEMP_EN(temp_en), .O_PIN_B(pb), .O_PIN_B_OE_N(pb_oe_n),
        .O_PIN_C(pc), .O_PIN_C_OE_N(pc_oe_n), .O_IRQ(irq));
    ssps_host_model HOST (.i_clk(clk), .i_select(sel), .i_pin_a(pa), .i_pin_b(pb), .i_pin_b_oe_n(pb_oe_n),
        .o_cs_n(cs_n), .o_b_level(b_level), .o_a_edges(a_edges));
    //==========================================================
    // helpers
    task automatic give_verdict;
        $display("counts: %0d compared, %0d errors", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk(32'(n < 50), 32'h1, "apb answer");
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // clock: 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog sized well above the whole sequence
    initial begin
        #80000;
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        give_verdict();
    end
    //==========================================================
    // main sequence
    initial begin : main
        logic [31:0] d;
        logic e;
        logic prev;
        int k, m;
        n_errors = 0;
        n_compared = 0;
        {rst_n, psel, pen, pwr, eop, under, flush, busy, sclk, sync, sel} = '0;
        {paddr, rssi, pwdata, fill} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk(pb_oe_n, 1'b1, "pin b released");
        chk(pa_oe_n, 1'b0, "pin a driven");
        rd(OFS_PIN_A, d);
        chk(d, 32'(RST_PIN_A), "cfg a reset");
        rd(OFS_PIN_B, d);
        chk(d, 32'(RST_PIN_B), "cfg b reset");
        rd(OFS_CTRL, d);
        chk(d, RST_CTRL, "ctrl reset");
        // divided clock: count cycles between two pin a edges
        for (k = 0; k < 2; k++) begin
            prev = pa;
            m = 0;
            while (pa === prev && m < 400) begin
                tick(1);
                m++;
            end
        end
        chk(32'(m), 32'(CLK_DIV / 2), "half period of pin a");
        chk(32'(a_edges != 16'h0), 32'h1, "host saw pin a edge");
        $display("test reset and clock done");
        for (k = 0; k < NROW; k++) begin
            fill <= rows[k].fill;
            rssi <= rows[k].rssi;
            busy <= rows[k].busy;
            sync <= rows[k].sync;
            sclk <= 1'b1;
            wr(OFS_CTRL, rows[k].ctrl);
            wr(OFS_PIN_C, {24'h0, rows[k].cfg});
            tick(3);
            chk(pc_oe_n, rows[k].oe_n, "pin c drive");
            if (rows[k].oe_n === 1'b0) chk(pc, rows[k].lvl, "pin c level");
        end
        $display("test selection table done");
        wr(OFS_IRQ_MASK, 32'h0000_0008);
        wr(OFS_IRQ_STAT, 32'h0000_001F);
        wr(OFS_PIN_C, 32'(SEL_TX_UNDER));
        under <= 1'b1;
        tick(1);
        under <= 1'b0;
        tick(3);
        chk(pc, 1'b1, "underflow sets pin");
        chk(irq, 1'b1, "underflow interrupt");
        tick(20);
        chk(pc, 1'b1, "underflow held");
        rd(OFS_IRQ_STAT, d);
        chk(d & 32'h0000_0808, 32'h0000_0808, "underflow status");
        wr(OFS_IRQ_STAT, 32'h0000_0008);
        tick(1);
        chk(irq, 1'b0, "interrupt cleared");
        flush <= 1'b1;
        tick(1);
        flush <= 1'b0;
        tick(2);
        chk(pc, 1'b0, "flush clears pin");
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        under <= 1'b1;
        tick(1);
        under <= 1'b0;
        tick(3);
        chk(irq, 1'b0, "masked interrupt");
        $display("test underflow done");
        fill <= 7'h05;
        wr(OFS_PIN_C, 32'(SEL_RX_THR_EOP));
        wr(OFS_IRQ_MASK, 32'h0000_0010);
        wr(OFS_IRQ_STAT, 32'h0000_001F);
        eop <= 1'b1;
        tick(1);
        eop <= 1'b0;
        tick(3);
        chk(irq, 1'b1, "packet end interrupt");
        chk(pc, 1'b1, "packet end on pin");
        fill <= 7'h00;
        tick(3);
        chk(pc, 1'b0, "packet end released");
        $display("test packet end done");
        wr(OFS_CTRL, 32'h000F_0000);
        // inverted, so the driven level differs from the released one
        wr(OFS_PIN_B, 32'(SEL_CCA) | 32'h0000_0040);
        tick(6);
        chk(pb_oe_n, 1'b0, "pin b driven when deselected");
        chk(b_level, 1'b0, "host reads pin b");
        sel <= 1'b1;
        tick(8);
        chk(pb_oe_n, 1'b1, "pin b released when selected");
        sel <= 1'b0;
        tick(8);
        chk(pb_oe_n, 1'b0, "pin b driven again");
        $display("test chip select done");
        wr(OFS_PIN_A, 32'(TEMP_CODE));
        tick(3);
        chk(temp_en, 1'b1, "temperature output");
        chk(pa_oe_n, 1'b1, "pin a digital off");
        wr(OFS_PIN_A, 32'(SEL_CCA));
        tick(3);
        chk(temp_en, 1'b0, "temperature off");
        chk(pa_oe_n, 1'b0, "pin a driven");
        chk(pa, 1'b1, "pin a new signal");
        apb(1'b0, 8'h20, 32'h0, d, e);
        chk(e, 1'b1, "unmapped error");
        chk(d, 32'h0, "unmapped reads zero");
        $display("test pin a and unmapped done");
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        rd(OFS_PIN_A, d);
        chk(d, 32'(RST_PIN_A), "cfg a after second reset");
        rd(OFS_PIN_C, d);
        chk(d, 32'(RST_PIN_C), "cfg c after second reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule // status_output_pin_selector_tb_top

/* src/ssps_pin_sel.sv */
// one pin's signal selector
`timescale 1ns/10ps
module ssps_pin_sel (
    // configuration
    input wire logic [5:0] i_sel,
    input wire logic i_inv,
    // status levels
    ssps_stat_if.dst st,
    // pin
    output logic o_level,
    output logic o_drive
);
    import ssps_pkg::*;

    logic raw;

    //==========================================================
    // decode the select code
    always_comb begin
        o_drive = 1'b1;
        case (i_sel)
            SEL_RX_THR_EOP: raw = st.rx_above;
            SEL_TX_UNDER: raw = st.under;
            SEL_CCA: raw = st.cca;
            SEL_SER_CLK: raw = st.ser_clk;
            SEL_CLK_DIV: raw = st.div_clk;
            SEL_HIZ: begin
                raw = 1'b0;
                o_drive = 1'b0;
            end
            default: raw = 1'b0;
        endcase
    end

    // inversion applies after selection; released pins stay low
    assign o_level = o_drive & (raw ^ i_inv);
endmodule // ssps_pin_sel

/* src/ssps_pkg.sv */
// constants shared by the status output pin selector
//==============================================================
package ssps_pkg;
    //==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_PIN_A = 8'h00;
    localparam logic [7:0] OFS_PIN_B = 8'h04;
    localparam logic [7:0] OFS_PIN_C = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    //==========================================================
    // config field layout: [5:0] select, [6] invert
    localparam int unsigned CFG_INV = 6;
    localparam int unsigned CTRL_CCA_LSB = 0;
    localparam int unsigned CTRL_RSSI_LSB = 8;
    localparam int unsigned CTRL_RXTHR_LSB = 16;
    localparam int unsigned IRQ_N = 5;
    //==========================================================
    // selection codes
    localparam logic [5:0] SEL_RX_THR_EOP = 6'h00;
    localparam logic [5:0] SEL_TX_UNDER = 6'h05;
    localparam logic [5:0] SEL_CCA = 6'h09;
    localparam logic [5:0] SEL_SER_CLK = 6'h0B;
    localparam logic [5:0] SEL_HIZ = 6'h2E;
    localparam logic [5:0] SEL_CLK_DIV = 6'h3F;
    localparam logic [7:0] TEMP_CODE = 8'h80;
    //==========================================================
    // values after reset
    localparam logic [7:0] RST_PIN_A = 8'h3F;
    localparam logic [7:0] RST_PIN_B = 8'h2E;
    localparam logic [7:0] RST_PIN_C = 8'h00;
    localparam logic [31:0] RST_CTRL = 32'h000F_0001;
    //==========================================================
    // crystal clock divider
    localparam int unsigned CLK_DIV = 192;
    localparam logic [6:0] DIV_HALF = 7'(CLK_DIV / 2);
endpackage

/* src/ssps_stat_if.sv */
// internal status levels offered to every pin selector
`timescale 1ns/10ps
interface ssps_stat_if;
    logic rx_above;
    logic under;
    logic cca;
    logic ser_clk;
    logic div_clk;
    modport src (output rx_above, under, cca, ser_clk, div_clk);
    modport dst (input rx_above, under, cca, ser_clk, div_clk);
endinterface // ssps_stat_if

/* src/ssps_top.sv */
// status output pin selector with apb registers
`timescale 1ns/10ps
module ssps_top (
    // clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_CLK_EN,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // radio status, same clock
    input wire logic [6:0] I_RX_FILL,
    input wire logic I_RX_EOP,
    input wire logic I_TX_UNDERFLOW,
    input wire logic I_TX_FLUSH,
    input wire logic [7:0] I_RSSI,
    input wire logic I_RX_BUSY,
    input wire logic I_SER_CLK,
    input wire logic I_SYNC_MODE,
    // chip select pin, asynchronous
    input wire logic I_CS_N,
    // output pins
    output logic O_PIN_A,
    output logic O_PIN_A_OE_N,
    output logic O_TEMP_EN,
    output logic O_PIN_B,
    output logic O_PIN_B_OE_N,
    output logic O_PIN_C,
    output logic O_PIN_C_OE_N,
    // interrupt
    output logic O_IRQ
);
    import ssps_pkg::*;

    ssps_stat_if st_if ();

    logic ce;
    logic setup;
    logic access;
    logic wr_en;

    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [7:0] cfg_c_q;
    logic [31:0] ctrl_q;
    logic [IRQ_N-1:0] irq_st_q;
    logic [IRQ_N-1:0] irq_st_d;
    logic [IRQ_N-1:0] irq_mask_q;
    logic [IRQ_N-1:0] irq_ev;

    logic [31:0] prdata_q;
    logic err_q;

    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic cs_n_q;

    logic [6:0] div_cnt_q;
    logic div_q;
    logic eop_q;
    logic under_q;

    logic [6:0] rx_lim;
    logic [1:0] channel_assess_mode;
    logic cca_lvl;

    logic [2:0] lvl;
    logic [2:0] drv;
    logic [2:0] lvl_q;
    logic [2:0] oe_n_q;
    logic temp_q;
    logic temp_sel;

    assign ce = I_CLK_EN;

    //==========================================================
    // apb decode
    //==========================================================
    // zero wait states: read data is caught in the setup cycle
    assign setup = I_PSEL & ~I_PENABLE;
    assign access = I_PSEL & I_PENABLE;
    assign O_PREADY = ce; // a frozen block holds the access
    assign O_PSLVERR = access & err_q;
    assign O_PRDATA = prdata_q;
    assign wr_en = access & I_PWRITE & ce & ~err_q;

    // is the address one of ours
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            OFS_PIN_A, OFS_PIN_B, OFS_PIN_C: mapped = 1'b1;
            OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // write strobe for one offset
    function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                    input logic [7:0] ofs);
        wr_hit = en & (a == ofs);
    endfunction

    //==========================================================
    // read data and error, captured at setup
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (ce && setup) begin
            err_q <= ~mapped(I_PADDR);
            case (I_PADDR)
                OFS_PIN_A: prdata_q <= {24'h00_0000, cfg_a_q};
                OFS_PIN_B: prdata_q <= {24'h00_0000, cfg_b_q};
                OFS_PIN_C: prdata_q <= {24'h00_0000, cfg_c_q};
                OFS_IRQ_STAT: prdata_q <= {20'h0_0000, under_q, lvl_q, 3'h0, irq_st_q};
                OFS_IRQ_MASK: prdata_q <= {27'h000_0000, irq_mask_q};
                OFS_CTRL: prdata_q <= ctrl_q;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    //==========================================================
    // per-pin configuration registers, each written alone
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cfg_a_q <= RST_PIN_A;
            cfg_b_q <= RST_PIN_B;
            cfg_c_q <= RST_PIN_C;
        end else begin
            if (wr_hit(wr_en, I_PADDR, OFS_PIN_A)) begin
                cfg_a_q <= I_PWDATA[7:0];
            end
            if (wr_hit(wr_en, I_PADDR, OFS_PIN_B)) begin
                cfg_b_q <= I_PWDATA[7:0];
            end
            if (wr_hit(wr_en, I_PADDR, OFS_PIN_C)) begin
                cfg_c_q <= I_PWDATA[7:0];
            end
        end
    end

    //==========================================================
    // control and interrupt mask
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ctrl_q <= RST_CTRL;
            irq_mask_q <= '0;
        end else begin
            if (wr_hit(wr_en, I_PADDR, OFS_CTRL)) begin
                ctrl_q <= I_PWDATA & 32'h000F_FF03;
            end
            if (wr_hit(wr_en, I_PADDR, OFS_IRQ_MASK)) begin
                irq_mask_q <= I_PWDATA[IRQ_N-1:0];
            end
        end
    end

    //==========================================================
    // sticky interrupt status, write one to clear
    // events: pin a/b/c rising, tx underflow, rx packet end
    assign irq_ev = {I_RX_EOP, I_TX_UNDERFLOW, lvl & ~lvl_q};

    always_comb begin
        irq_st_d = irq_st_q;
        if (wr_hit(wr_en, I_PADDR, OFS_IRQ_STAT)) begin
            irq_st_d = irq_st_d & ~I_PWDATA[IRQ_N-1:0];
        end
        // a new event beats a clear in the same cycle
        irq_st_d = irq_st_d | irq_ev;
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            irq_st_q <= '0;
        end else if (ce) begin
            irq_st_q <= irq_st_d;
        end
    end

    assign O_IRQ = |(irq_st_q & irq_mask_q);

    //==========================================================
    // chip select synchroniser, three stages
    //==========================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            cs_n_q <= 1'b1;
        end else if (ce) begin
            cs_s1_q <= I_CS_N;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            // accept a change only once two stages agree
            if (cs_s2_q == cs_s3_q) begin
                cs_n_q <= cs_s3_q;
            end
        end
    end

    //==========================================================
    // crystal clock divided by the divider constant
    //==========================================================
    // runs from reset so the host can be clocked from it
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            div_cnt_q <= 7'h00;
            div_q <= 1'b0;
        end else if (ce) begin
            if (div_cnt_q == DIV_HALF - 7'h01) begin
                div_cnt_q <= 7'h00;
                div_q <= ~div_q;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
        end
    end

    //==========================================================
    // rx threshold and packet end
    //==========================================================
    // limit is four bytes per threshold step, up to 64
    assign rx_lim = {1'b0, ctrl_q[CTRL_RXTHR_LSB +: 4], 2'b00} + 7'h04;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            eop_q <= 1'b0;
        end else if (ce) begin
            // packet end holds until the fifo runs empty
            if (I_RX_EOP) begin
                eop_q <= 1'b1;
            end else if (I_RX_FILL == 7'h00) begin
                eop_q <= 1'b0;
            end
        end
    end

    assign st_if.rx_above = (I_RX_FILL > rx_lim) | eop_q;

    //==========================================================
    // tx underflow flag
    //==========================================================
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            under_q <= 1'b0;
        end else if (ce) begin
            // underflow wins over a flush in the same cycle
            if (I_TX_UNDERFLOW) begin
                under_q <= 1'b1;
            end else if (I_TX_FLUSH) begin
                under_q <= 1'b0;
            end
        end
    end

    assign st_if.under = under_q;

    //==========================================================
    // clear channel assessment
    //==========================================================
    assign channel_assess_mode = ctrl_q[CTRL_CCA_LSB +: 2];

    always_comb begin
        case (channel_assess_mode)
            2'h0: cca_lvl = 1'b1;
            2'h1: cca_lvl = I_RSSI < ctrl_q[CTRL_RSSI_LSB +: 8];
            2'h2: cca_lvl = ~I_RX_BUSY;
            2'h3: cca_lvl = (I_RSSI < ctrl_q[CTRL_RSSI_LSB +: 8]) & ~I_RX_BUSY;
            default: cca_lvl = 1'b0;
        endcase
    end

    assign st_if.cca = cca_lvl;
    assign st_if.ser_clk = I_SER_CLK & I_SYNC_MODE;
    assign st_if.div_clk = div_q;

    //==========================================================
    // pin selectors
    //==========================================================
    ssps_pin_sel u_sel_a (
        .i_sel(cfg_a_q[5:0]),
        .i_inv(cfg_a_q[CFG_INV]),
        .st(st_if),
        .o_level(lvl[0]),
        .o_drive(drv[0])
    );

    ssps_pin_sel u_sel_b (
        .i_sel(cfg_b_q[5:0]),
        .i_inv(cfg_b_q[CFG_INV]),
        .st(st_if),
        .o_level(lvl[1]),
        .o_drive(drv[1])
    );

    ssps_pin_sel u_sel_c (
        .i_sel(cfg_c_q[5:0]),
        .i_inv(cfg_c_q[CFG_INV]),
        .st(st_if),
        .o_level(lvl[2]),
        .o_drive(drv[2])
    );

    // the whole byte must match, not only the select field
    assign temp_sel = (cfg_a_q == TEMP_CODE);

    //==========================================================
    // registered pin drivers
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            lvl_q <= 3'h0;
            oe_n_q <= 3'h7;
            temp_q <= 1'b0;
        end else if (ce) begin
            lvl_q <= lvl;
            temp_q <= temp_sel;
            oe_n_q[0] <= ~drv[0] | temp_sel;
            // pin b belongs to the serial bus while selected
            oe_n_q[1] <= ~drv[1] | ~cs_n_q;
            oe_n_q[2] <= ~drv[2];
        end
    end

    assign O_PIN_A = lvl_q[0];
    assign O_PIN_B = lvl_q[1];
    assign O_PIN_C = lvl_q[2];
    assign O_PIN_A_OE_N = oe_n_q[0];
    assign O_PIN_B_OE_N = oe_n_q[1];
    assign O_PIN_C_OE_N = oe_n_q[2];
    assign O_TEMP_EN = temp_q;

    //==========================================================
    // assertions
    //==========================================================
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    a_temp_release: assert property (
        ce && cfg_a_q == TEMP_CODE |=> O_PIN_A_OE_N && O_TEMP_EN)
        else $error("pin a driven while temperature selected");

    a_b_bus_owned: assert property (
        ce && !cs_n_q |=> O_PIN_B_OE_N)
        else $error("pin b driven while chip select low");

    a_b_reset_hiz: assert property (
        @(posedge I_CLOCK) disable iff (1'b0) !I_RST_N |=> O_PIN_B_OE_N && cfg_b_q == RST_PIN_B)
        else $error("pin b not released after reset");

    a_div_toggle: assert property (
        ce && div_cnt_q == DIV_HALF - 7'h01 |=> div_q != $past(div_q) && div_cnt_q == 7'h00)
        else $error("divided clock missed its half period");

    a_cfg_a_write: assert property (
        wr_hit(wr_en, I_PADDR, OFS_PIN_A) |=> cfg_a_q == $past(I_PWDATA[7:0]))
        else $error("pin a config not updated");

    a_pin_indep: assert property (
        wr_hit(wr_en, I_PADDR, OFS_PIN_B) |=> $stable(cfg_a_q) && $stable(cfg_c_q))
        else $error("write to pin b touched another pin");

    a_rx_level: assert property (
        ce && cfg_c_q == 8'h00 |=> O_PIN_C == $past(st_if.rx_above))
        else $error("pin c does not follow rx threshold");

    a_under_hold: assert property (
        ce && under_q && !I_TX_FLUSH |=> under_q)
        else $error("underflow flag dropped without flush");

    a_under_clear: assert property (
        ce && I_TX_FLUSH && !I_TX_UNDERFLOW |=> !under_q)
        else $error("underflow flag not cleared by flush");

    a_cca_level: assert property (
        ce && cfg_c_q == {2'h0, SEL_CCA} |=> O_PIN_C == $past(cca_lvl))
        else $error("pin c does not follow clear channel");

    a_ser_clk: assert property (
        ce && cfg_c_q == {2'h0, SEL_SER_CLK} && !I_SYNC_MODE |=> !O_PIN_C)
        else $error("serial clock out of synchronous mode");

    a_reserved_low: assert property (
        ce && cfg_c_q == 8'h07 |=> !O_PIN_C && !O_PIN_C_OE_N)
        else $error("reserved code not driven low");

    c_temp_mode: cover property (ce && temp_sel ##1 O_TEMP_EN);
    c_irq_fire: cover property ($rose(O_IRQ));
    c_b_driven: cover property (!O_PIN_B_OE_N);
endmodule // ssps_top
